//--- logic/hmr_defines.vh
`ifndef HMR_DEFINES_VH
`define HMR_DEFINES_VH

// integer measurement bank, protocol addresses
`define HMR_A_RH          16'h0100
`define HMR_A_TEMP        16'h0101
`define HMR_A_DEW         16'h0103
`define HMR_A_DEWFROST    16'h0104
`define HMR_A_DEWFROST_AT 16'h0105
`define HMR_A_DEW_AT      16'h0106
`define HMR_A_ABSHUM      16'h0107
`define HMR_A_MIXRATIO    16'h0108
`define HMR_A_WETBULB     16'h0109
`define HMR_A_VAPCONC     16'h010a
`define HMR_A_VAPPRESS    16'h010b
`define HMR_A_SATPRESS    16'h010c
`define HMR_A_ENTHALPY    16'h010d
`define HMR_A_WATERACT    16'h010e
`define HMR_A_DEWDIFF     16'h010f
`define HMR_A_ABSHUM_NTP  16'h0110
`define HMR_A_OILPPM      16'h0111
`define HMR_A_RELSAT      16'h0114
`define HMR_A_WETBASIS    16'h0115
`define HMR_A_RH_FROST    16'h0116
`define HMR_A_MASSFRAC    16'h0120

// measurement slot count
`define HMR_N_MEAS        21

// configuration bank
`define HMR_A_EXTRA_HEAT  16'h0506
`define HMR_A_PROBE_HEAT  16'h0508
`define HMR_A_TCOMP_LO    16'h0334
`define HMR_A_TCOMP_HI    16'h0335
`define HMR_A_USER_BASE   16'h0a00
`define HMR_USER_WORDS    12
`define HMR_EXTRA_HEAT_RST 1'b0
`define HMR_PROBE_HEAT_RST 1'b0

// 16-bit signed special codes
`define HMR_NA            16'h8000
`define HMR_SAT_HI        16'h7fff
`define HMR_SAT_LO        16'h8001

// register number to protocol address offset
`define HMR_REGNUM_OFS    16'h0001

`endif

//--- logic/hmr_register_map.v
// Function
// - measurements read-only signed 16-bit, writes refused, with error when no read is requested in the same cycle
// - temperatures in degC times 100
// - vapour pressures in hPa times 10
// - wet-basis concentration in vol-% times 100
// - abs_humidity_ntp_int g/m3 times 100
// - oil moisture ppmw unscaled
// - extra-heat boolean, default off
// - extra heat cycle freezes measurement updates
// - 24-byte user text at 0a00 onward
// - configuration bank writable by master
// - unavailable 8000, saturate 7fff and 8001
// - protocol address is register number minus one
`timescale 1ns/10ps
`include "hmr_defines.vh"

module hmr_register_map #(
    parameter MW = 32
) (
    input  wire        clk,
    input  wire        rst,
    // protocol data unit access, same clock domain
    input  wire        reg_rd,
    input  wire        reg_wr,
    input  wire [15:0] reg_addr,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata_r,
    output reg         reg_ack_r,
    output reg         reg_err_r,
    // measurement engine: 21 slots of MW-bit signed scaled values
    input  wire [`HMR_N_MEAS*MW-1:0] meas_val,
    input  wire [`HMR_N_MEAS-1:0]    meas_ok,
    input  wire        meas_upd,
    input  wire        heat_busy,
    // controls to the probe
    output reg         extra_heat_en_r,
    output reg         probe_heat_en_r,
    output reg         tcomp_valid_r
);

    ////////////////////////////////////////////////////////////////////
    // slot index returned for addresses outside the measurement bank
    localparam [4:0] SLOT_NONE = 5'd31;

    ////////////////////////////////////////////////////////////////////
    // saturate one scaled value into the signed 16-bit code space
    function [15:0] sat16;
        input [MW-1:0] v;
        input          ok;
        begin
            if (!ok)
                sat16 = `HMR_NA;
            else if (!v[MW-1] && (v > {{(MW-15){1'b0}}, 15'h7ffe}))
                sat16 = `HMR_SAT_HI;
            else if (v[MW-1] && (v < {{(MW-15){1'b1}}, 15'h0002}))
                sat16 = `HMR_SAT_LO;
            else
                sat16 = v[15:0];
        end
    endfunction

    // slots derived from measured temperature, blanked under probe heat without supplied temperature
    function temp_dep;
        input integer i;
        begin
            case (i)
                0:       temp_dep = 1'b1;   // relative humidity
                2:       temp_dep = 1'b1;   // dew point
                3:       temp_dep = 1'b1;   // dew or frost point
                4:       temp_dep = 1'b1;   // dew or frost at 1 atm
                5:       temp_dep = 1'b1;   // dew_point_atm_int
                6:       temp_dep = 1'b1;   // absolute humidity
                7:       temp_dep = 1'b1;   // mixing ratio
                8:       temp_dep = 1'b1;   // wet-bulb temperature
                13:      temp_dep = 1'b1;   // water activity
                14:      temp_dep = 1'b1;   // dew point difference
                17:      temp_dep = 1'b1;   // relative saturation
                19:      temp_dep = 1'b1;   // humidity over ice
                default: temp_dep = 1'b0;
            endcase
        end
    endfunction

    // map protocol address to slot index, 31 when none
    function [4:0] slot_of;
        input [15:0] a;
        begin
            case (a)
                `HMR_A_RH:          slot_of = 5'd0;
                `HMR_A_TEMP:        slot_of = 5'd1;
                `HMR_A_DEW:         slot_of = 5'd2;
                `HMR_A_DEWFROST:    slot_of = 5'd3;
                `HMR_A_DEWFROST_AT: slot_of = 5'd4;
                `HMR_A_DEW_AT:      slot_of = 5'd5;
                `HMR_A_ABSHUM:      slot_of = 5'd6;
                `HMR_A_MIXRATIO:    slot_of = 5'd7;
                `HMR_A_WETBULB:     slot_of = 5'd8;
                `HMR_A_VAPCONC:     slot_of = 5'd9;
                `HMR_A_VAPPRESS:    slot_of = 5'd10;
                `HMR_A_SATPRESS:    slot_of = 5'd11;
                `HMR_A_ENTHALPY:    slot_of = 5'd12;
                `HMR_A_WATERACT:    slot_of = 5'd13;
                `HMR_A_DEWDIFF:     slot_of = 5'd14;
                `HMR_A_ABSHUM_NTP:  slot_of = 5'd15;
                `HMR_A_OILPPM:      slot_of = 5'd16;
                `HMR_A_RELSAT:      slot_of = 5'd17;
                `HMR_A_WETBASIS:    slot_of = 5'd18;
                `HMR_A_RH_FROST:    slot_of = 5'd19;
                `HMR_A_MASSFRAC:    slot_of = 5'd20;
                default:            slot_of = SLOT_NONE;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    reg  [15:0] meas_r   [0:`HMR_N_MEAS-1];
    reg  [15:0] meas_nxt [0:`HMR_N_MEAS-1];
    reg  [15:0] user_r   [0:`HMR_USER_WORDS-1];
    reg  [15:0] tcomp_r  [0:1];
    reg         blank;
    reg  [4:0]  slot;
    reg  [15:0] uidx;
    reg         is_user;
    reg         is_meas;
    reg         is_heat;
    reg         is_probe;
    reg         is_tc_lo;
    reg         is_tc_hi;
    reg         wr_ok;
    reg         rd_ok;
    reg  [15:0] rd_mux;
    integer     i;
    integer     j;
    integer     k;

    ////////////////////////////////////////////////////////////////////
    // decode of current address
    always @* begin
        slot     = slot_of(reg_addr);
        is_meas  = (slot != SLOT_NONE);
        is_heat  = (reg_addr == `HMR_A_EXTRA_HEAT);
        is_probe = (reg_addr == `HMR_A_PROBE_HEAT);
        is_tc_lo = (reg_addr == `HMR_A_TCOMP_LO);
        is_tc_hi = (reg_addr == `HMR_A_TCOMP_HI);
        // wraps below the text base, so the lower bound is kept too
        uidx     = reg_addr - `HMR_A_USER_BASE;
        is_user  = (reg_addr >= `HMR_A_USER_BASE) &&
                   (uidx < `HMR_USER_WORDS);
        // writable set: measurement bank is never part of it
        wr_ok    = is_heat || is_probe || is_tc_lo || is_tc_hi ||
                   is_user;
        rd_ok    = is_meas || wr_ok;
        // temperature outputs need either own or supplied temperature
        blank    = probe_heat_en_r && !tcomp_valid_r;
    end

    ////////////////////////////////////////////////////////////////////
    // read data selection, zero for unmapped addresses
    always @* begin
        rd_mux = 16'h0000;
        if (is_meas)
            rd_mux = meas_r[slot];
        else if (is_heat)
            rd_mux = {15'h0000, extra_heat_en_r};
        else if (is_probe)
            rd_mux = {15'h0000, probe_heat_en_r};
        else if (is_tc_lo)
            rd_mux = tcomp_r[0];
        else if (is_tc_hi)
            rd_mux = tcomp_r[1];
        else if (is_user)
            rd_mux = user_r[uidx[3:0]];
    end

    ////////////////////////////////////////////////////////////////////
    // next snapshot value per slot: blanked, saturated or unavailable
    always @* begin
        for (k = 0; k < `HMR_N_MEAS; k = k + 1) begin
            if (blank && temp_dep(k))
                meas_nxt[k] = `HMR_NA;
            else
                meas_nxt[k] = sat16(meas_val[k*MW +: MW],
                                    meas_ok[k]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // measurement snapshot, frozen during extra heat cycle
    always @(posedge clk) begin
        if (rst) begin
            for (i = 0; i < `HMR_N_MEAS; i = i + 1)
                meas_r[i] <= `HMR_NA;
        end else if (meas_upd && !heat_busy) begin
            for (i = 0; i < `HMR_N_MEAS; i = i + 1)
                meas_r[i] <= meas_nxt[i];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // extra heat boolean, bit 0 of its word
    always @(posedge clk) begin
        if (rst)
            extra_heat_en_r <= `HMR_EXTRA_HEAT_RST;
        else if (reg_wr && is_heat)
            extra_heat_en_r <= reg_wdata[0];
    end

    ////////////////////////////////////////////////////////////////////
    // probe heating boolean, bit 0 of its word
    always @(posedge clk) begin
        if (rst)
            probe_heat_en_r <= `HMR_PROBE_HEAT_RST;
        else if (reg_wr && is_probe)
            probe_heat_en_r <= reg_wdata[0];
    end

    ////////////////////////////////////////////////////////////////////
    // external temperature words, stored as written
    always @(posedge clk) begin
        if (rst) begin
            tcomp_r[0] <= 16'h0000;
            tcomp_r[1] <= 16'h0000;
        end else if (reg_wr) begin
            if (is_tc_lo)
                tcomp_r[0] <= reg_wdata;
            if (is_tc_hi)
                tcomp_r[1] <= reg_wdata;
        end
    end

    // sticky until reset: set once the master supplies a temperature
    always @(posedge clk) begin
        if (rst)
            tcomp_valid_r <= 1'b0;
        else if (reg_wr && (is_tc_lo || is_tc_hi))
            tcomp_valid_r <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // user text, 12 words of two bytes each
    always @(posedge clk) begin
        if (rst) begin
            for (j = 0; j < `HMR_USER_WORDS; j = j + 1)
                user_r[j] <= 16'h0000;
        end else if (reg_wr && is_user) begin
            user_r[uidx[3:0]] <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // acknowledge: one pulse on the edge after each request
    always @(posedge clk) begin
        if (rst)
            reg_ack_r <= 1'b0;
        else
            reg_ack_r <= reg_rd || reg_wr;
    end

    ////////////////////////////////////////////////////////////////////
    // error flag: unmapped read, or write outside the writable set with no read requested
    always @(posedge clk) begin
        if (rst)
            reg_err_r <= 1'b0;
        else if (reg_rd)
            reg_err_r <= !rd_ok;
        else if (reg_wr)
            reg_err_r <= !wr_ok;
        else
            reg_err_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // read data stands with the acknowledge only, zero otherwise
    always @(posedge clk) begin
        if (rst)
            reg_rdata_r <= 16'h0000;
        else if (reg_rd)
            reg_rdata_r <= rd_mux;
        else
            reg_rdata_r <= 16'h0000;
    end

endmodule

//--- verification/hmr_register_map_asserts.sv
`timescale 1ns/10ps
module hmr_register_map_asserts #(parameter MW = 32) (
    input wire             clk,
    input wire             rst,
    input wire             reg_rd,
    input wire             reg_wr,
    input wire [15:0]      reg_addr,
    input wire [15:0]      reg_wdata,
    input wire [15:0]      reg_rdata_r,
    input wire             reg_ack_r,
    input wire             reg_err_r,
    input wire [21*MW-1:0] meas_val,
    input wire [20:0]      meas_ok,
    input wire             meas_upd,
    input wire             heat_busy,
    input wire             extra_heat_en_r,
    input wire             probe_heat_en_r,
    input wire             tcomp_valid_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // answer timing of the access port
    a_ack_next: assert property ((reg_rd | reg_wr) |=> reg_ack_r)
        else $error("request not answered");
    a_no_stray: assert property (!(reg_rd | reg_wr) |=>
        !reg_ack_r && reg_rdata_r == 16'h0000) else $error("stray answer");
    // measurement bank refuses writes, user text accepts them
    a_meas_ro: assert property (reg_wr && !reg_rd && reg_addr >= 16'h0100
        && reg_addr <= 16'h0120 |=> reg_err_r) else $error("ro write ok");
    a_user_ok: assert property (reg_wr && reg_addr >= 16'h0a00
        && reg_addr <= 16'h0a0b |=> !reg_err_r) else $error("text refused");
    // configuration booleans follow their writes, extra heat holds otherwise
    a_heat_wr: assert property (reg_wr && reg_addr == 16'h0506 |=>
        extra_heat_en_r == $past(reg_wdata[0])) else $error("heat bit");
    a_heat_hold: assert property (!(reg_wr && reg_addr == 16'h0506) |=>
        $stable(extra_heat_en_r)) else $error("heat bit moved");
    a_probe_wr: assert property (reg_wr && reg_addr == 16'h0508 |=>
        probe_heat_en_r == $past(reg_wdata[0])) else $error("probe bit");
    a_tcomp_set: assert property ((reg_wr && reg_addr == 16'h0334)
        || tcomp_valid_r |=> tcomp_valid_r) else $error("tcomp flag");
    c_frozen: cover property (meas_upd && heat_busy);
    c_err: cover property (reg_ack_r && reg_err_r);
    c_blank: cover property (meas_upd && probe_heat_en_r && !tcomp_valid_r);
endmodule
////////////////////////////////////////////////////////////////////////////
bind hmr_register_map hmr_register_map_asserts #(.MW(MW)) u_chk (
    .clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .reg_ack_r(reg_ack_r), .reg_err_r(reg_err_r), .meas_val(meas_val),
    .meas_ok(meas_ok), .meas_upd(meas_upd), .heat_busy(heat_busy),
    .extra_heat_en_r(extra_heat_en_r), .probe_heat_en_r(probe_heat_en_r),
    .tcomp_valid_r(tcomp_valid_r));

//--- verification/hmr_master_model.sv
`timescale 1ns/10ps
// plc side: one pdu register request per call
module hmr_master_model (
    input  wire        clk,
    output reg         reg_rd,
    output reg         reg_wr,
    output reg  [15:0] reg_addr,
    output reg  [15:0] reg_wdata,
    input  wire [15:0] reg_rdata_r,
    input  wire        reg_ack_r,
    input  wire        reg_err_r
);
    initial {reg_rd, reg_wr, reg_addr, reg_wdata} = 34'h0;
    task xfer(input w, input [15:0] a, d, output [15:0] q, output e, k);
        begin
        @(posedge clk);
        reg_rd <= !w;
        reg_wr <= w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        reg_addr <= ~a; // released lines lose their value
        reg_wdata <= ~d;
        #1;
        q = reg_rdata_r;
        e = reg_err_r;
        k = reg_ack_r;
        end
    endtask
endmodule

//--- verification/hmr_register_map_tb.sv
`timescale 1ns/10ps
module hmr_register_map_tb;
    localparam MW = 32;
    reg             clk = 1'b0;
    reg             rst = 1'b1;
    reg [21*MW-1:0] meas_val = 0;
    reg [20:0]      meas_ok = 21'h0;
    reg             meas_upd = 1'b0;
    reg             heat_busy = 1'b0;
    wire            rd, wr, ack, err, heat_en, probe_en, tc_ok;
    wire [15:0]     addr, wdata, rdata;
    integer         errors = 0;
    integer         checks_done = 0;
    always #5 clk = ~clk;
    hmr_register_map #(.MW(MW)) u_dut (.clk(clk), .rst(rst), .reg_rd(rd),
        .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_r(rdata),
        .reg_ack_r(ack), .reg_err_r(err), .meas_val(meas_val),
        .meas_ok(meas_ok), .meas_upd(meas_upd), .heat_busy(heat_busy),
        .extra_heat_en_r(heat_en), .probe_heat_en_r(probe_en),
        .tcomp_valid_r(tc_ok));
    hmr_master_model u_mst (.clk(clk), .reg_rd(rd), .reg_wr(wr),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_r(rdata),
        .reg_ack_r(ack), .reg_err_r(err));
    task cmp(input [63:0] nm, input [15:0] ex, sn);
        begin
        checks_done = checks_done + 1;
        if (ex !== sn) begin
            errors = errors + 1;
            $display("ERROR %0s expected %h seen %h", nm, ex, sn);
        end
        end
    endtask
    task chk(input w, input [15:0] a, d, eq, input ee);
        reg [15:0] q;
        reg        e, k;
        begin
        u_mst.xfer(w, a, d, q, e, k);
        cmp("ack", 16'h1, {15'h0, k});
        cmp("err", {15'h0, ee}, {15'h0, e});
        if (!w) cmp("rdata", eq, q);
        end
    endtask
    task put(input integer i, input [31:0] v);
        begin
        @(posedge clk);
        meas_val[i*MW +: MW] <= v;
        meas_ok[i] <= 1'b1;
        end
    endtask
    task upd(input busy);
        begin
        @(posedge clk);
        heat_busy <= busy;
        meas_upd <= 1'b1;
        @(posedge clk);
        meas_upd <= 1'b0;
        heat_busy <= 1'b0;
        end
    endtask
    task stop_test;
        begin
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // about 75 cycles of traffic, so 10000 cycles means a hang
    initial begin
        #100000;
        errors = errors + 1;
        stop_test;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        chk(0, 16'h0101, 0, 16'h8000, 0);
        chk(0, 16'h0506, 0, 16'h0000, 0);
        cmp("tc_ok", 16'h0, {15'h0, tc_ok});
        $display("test reset done");
        put(0, 40000); put(1, 2512); put(2, -40000); put(11, 10132);
        put(15, 850); put(16, 123); put(18, 32766); upd(0);
        chk(0, 16'h0100, 0, 16'h7fff, 0);
        chk(0, 16'h0101, 0, 16'h09d0, 0);
        chk(0, 16'h0103, 0, 16'h8001, 0);
        chk(0, 16'h0104, 0, 16'h8000, 0);
        chk(0, 16'h010c, 0, 16'h2794, 0);
        chk(0, 16'h0110, 0, 16'h0352, 0);
        chk(0, 16'h0111, 0, 16'h007b, 0);
        chk(0, 16'h0115, 0, 16'h7ffe, 0);
        chk(1, 16'h0101, 16'h1234, 0, 1);
        chk(0, 16'h0101, 0, 16'h09d0, 0);
        put(1, 100); upd(1);
        chk(0, 16'h0101, 0, 16'h09d0, 0);
        $display("test capture done");
        chk(1, 16'h0506, 16'h0001, 0, 0);
        cmp("heat_en", 16'h1, {15'h0, heat_en});
        chk(0, 16'h0506, 0, 16'h0001, 0);
        chk(1, 16'h0508, 16'h0001, 0, 0);
        cmp("probe_en", 16'h1, {15'h0, probe_en});
        upd(0);
        chk(0, 16'h0100, 0, 16'h8000, 0);
        chk(0, 16'h0101, 0, 16'h0064, 0);
        chk(1, 16'h0334, 16'h09c4, 0, 0);
        cmp("tc_ok", 16'h1, {15'h0, tc_ok});
        upd(0);
        chk(0, 16'h0100, 0, 16'h7fff, 0);
        chk(0, 16'h0101, 0, 16'h0064, 0);
        $display("test config done");
        chk(1, 16'h0a00, 16'h4142, 0, 0);
        chk(1, 16'h0a0b, 16'he282, 0, 0);
        chk(0, 16'h0a00, 0, 16'h4142, 0);
        chk(0, 16'h0a0b, 0, 16'he282, 0);
        chk(1, 16'h0a0c, 16'h0001, 0, 1);
        chk(0, 16'h0000, 0, 16'h0000, 1);
        $display("test text done");
        stop_test;
    end
endmodule
